// ===== pkg/dhc_defs.vh
/*
 * Constants for the terminal handshake and configuration block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 200 MHz mclk; included by the design file and by the bench.
 */
`ifndef DHC_DEFS_VH
`define DHC_DEFS_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define DHC_ADDR_CFG    8'h00
`define DHC_ADDR_CTL    8'h04
`define DHC_ADDR_STAT   8'h08

// ==========================================================
// Line rate codes (software encoding)
`define DHC_LR_2400     3'h0
`define DHC_LR_4800     3'h1
`define DHC_LR_9600     3'h2
`define DHC_LR_19200    3'h3
`define DHC_LR_56K      3'h4
`define DHC_LR_64K      3'h5

// ==========================================================
// Terminal rate codes (rate converter)
`define DHC_TR_2400     3'h0
`define DHC_TR_4800     3'h1
`define DHC_TR_9600     3'h2
`define DHC_TR_19200    3'h3
`define DHC_TR_38400    3'h4
`define DHC_TR_LINE     3'h7

// ==========================================================
// Config register fields
`define DHC_F_LR_LO     0
`define DHC_F_CA        3
`define DHC_F_FRTS      4
`define DHC_F_CLEN      5
`define DHC_F_ASYNC     6
`define DHC_F_TR_LO     7
`define DHC_F_LOOPCTL   10
`define DHC_F_GUARD     11
`define DHC_F_EXTDLY    12
`define DHC_CFG_RESET   13'h0394

// ==========================================================
// Timing: 200 MHz, 1 ms = 200000 cycles, 1 s = 200000000 cycles
`define DHC_CLK_MHZ     200
`define DHC_US_CYCLES   200
`define DHC_US_PER_S    1000000
`define DHC_GUARD_S_56  2
`define DHC_GUARD_S_192 4
`define DHC_GUARD_S_96  8
`define DHC_GUARD_S_48  15
`define DHC_GUARD_S_24  30
`define DHC_GUARD_S_MAX 30
// Turn-on delays in microseconds (normal / extended)
`define DHC_DLY_N_56    300
`define DHC_DLY_N_192   900
`define DHC_DLY_N_96    1900
`define DHC_DLY_N_48    3800
`define DHC_DLY_N_24    7500
`define DHC_DLY_E_56    1300
`define DHC_DLY_E_192   3800
`define DHC_DLY_E_96    7500
`define DHC_DLY_E_48    15000
`define DHC_DLY_E_24    30000

`endif

// ===== logic/dhc_ctrl.v
/*
 * Terminal handshake and configuration control: rate selection, loop
 * requests, anti-stream guard, send-to-clear delay, circuit assurance.
 * Assumes switches and terminal pins are asynchronous; registers are
 * reached over a simple strobe port on mclk.
 * The management menu and its serial port sit outside; a register write
 * stands for one stored menu choice. Timer lengths scale with two
 * parameters so that a test can run the guard and delay timers short.
 */
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "dhc_defs.vh"

module dhc_ctrl #(
  parameter US_CYCLES = `DHC_US_CYCLES,
  parameter S_US = `DHC_US_PER_S
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Line rate and set 1 switches (high = On)
  input wire [2:0] line_rate_switch,
  input wire assurance_switch,
  input wire force_rts_switch,
  input wire char_len_switch,
  input wire data_format_switch,
  // Set 2 switches (high = On)
  input wire rate_select_bit0,
  input wire rate_select_bit1,
  input wire rate_select_bit2,
  input wire terminal_loop_ctl_switch,
  input wire stream_guard_switch,
  input wire turn_on_delay_switch,
  // Terminal handshake pins
  input wire send_request,
  input wire local_loop_request,
  input wire remote_loop_request,
  output reg clear_to_send,
  // Receiver state
  input wire rx_no_signal,
  input wire carrier_detect,
  // Resulting controls
  output reg tx_enable,
  output reg local_loop_active,
  output reg remote_loop_active,
  output reg [2:0] line_rate,
  output reg [2:0] terminal_rate,
  output reg async_convert,
  output reg char_len_11,
  output reg line_sync
);

  // ==========================================================
  // Input synchronisers: two flops before any logic
  // Every switch and pin is a slow level from outside the mclk domain,
  // so one shared two-stage chain is enough; the bit order below must
  // match the slices taken from the second stage further down.
  localparam NSYNC = 18;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  assign raw_in = {
    line_rate_switch,
    assurance_switch,
    force_rts_switch,
    char_len_switch,
    data_format_switch,
    rate_select_bit2,
    rate_select_bit1,
    rate_select_bit0,
    terminal_loop_ctl_switch,
    stream_guard_switch,
    turn_on_delay_switch,
    send_request,
    local_loop_request,
    remote_loop_request,
    rx_no_signal,
    carrier_detect
  };

  // Synchronously resampled switches and pins
  always @(posedge mclk) begin
    if (!rstn) begin
      sync1_reg <= {NSYNC{1'b0}};
      sync2_reg <= {NSYNC{1'b0}};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire [2:0] s_lr = sync2_reg[17:15];
  wire s_ca = sync2_reg[14];
  wire s_frts = sync2_reg[13];
  wire s_clen = sync2_reg[12];
  wire s_fmt = sync2_reg[11];
  wire [2:0] s_rsel = sync2_reg[10:8];
  wire s_loopctl = sync2_reg[7];
  wire s_guard = sync2_reg[6];
  wire s_dly = sync2_reg[5];
  wire s_rts = sync2_reg[4];
  wire s_ll = sync2_reg[3];
  wire s_rl = sync2_reg[2];
  wire s_nosig = sync2_reg[1];
  wire s_cd = sync2_reg[0];

  // ==========================================================
  // Software registers
  reg [12:0] sw_cfg_reg;
  reg sw_ctl_reg;

  // Register writes; unmapped offsets are ignored
  // Settings change only on a write, so a menu left without a choice
  // leaves everything as it was
  always @(posedge mclk) begin
    if (!rstn) begin
      sw_cfg_reg <= `DHC_CFG_RESET;
      sw_ctl_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `DHC_ADDR_CFG) // Only the addressed word
        sw_cfg_reg <= reg_wdata[12:0];
      if (reg_addr == `DHC_ADDR_CTL)
        sw_ctl_reg <= reg_wdata[0];
    end
  end

  // ==========================================================
  // Decode hardware switches into software encoding
  reg [2:0] hw_lr;
  reg [2:0] hw_tr;
  reg hw_valid;

  // Line rate switch table; all-Off keeps hardware pointer
  // The all-Off and unused codes also clear hw_valid, which pins the
  // configuration to the switches whatever software asked for
  always @* begin
    hw_valid = 1'b1;
    case (s_lr)
      3'h7: hw_lr = `DHC_LR_2400;
      3'h6: hw_lr = `DHC_LR_4800;
      3'h5: hw_lr = `DHC_LR_9600;
      3'h4: hw_lr = `DHC_LR_19200;
      3'h3: hw_lr = `DHC_LR_56K;
      3'h2: hw_lr = `DHC_LR_64K;
      default: begin
        hw_lr = `DHC_LR_56K;
        hw_valid = 1'b0;
      end
    endcase
  end

  // Rate converter switches, bit order {bit2,bit1,bit0}
  // All-Off and the unused codes mean no conversion; the terminal then
  // runs at the line rate
  always @* begin
    case (s_rsel)
      3'h7: hw_tr = `DHC_TR_2400;
      3'h6: hw_tr = `DHC_TR_4800;
      3'h5: hw_tr = `DHC_TR_9600;
      3'h4: hw_tr = `DHC_TR_19200;
      3'h3: hw_tr = `DHC_TR_38400;
      default: hw_tr = `DHC_TR_LINE;
    endcase
  end

  // ==========================================================
  // Active configuration selection
  // One pointer picks every field, so a setting never mixes sources;
  // switch polarities are folded in here, not in the logic below
  wire use_sw = sw_ctl_reg & hw_valid; // Hardware unless software chosen
  wire [2:0] a_lr = use_sw ? sw_cfg_reg[2:0] : hw_lr;
  wire a_ca = use_sw ? sw_cfg_reg[`DHC_F_CA] : s_ca;
  wire a_frts = use_sw ? sw_cfg_reg[`DHC_F_FRTS] : ~s_frts; // Off = forced
  wire a_clen = use_sw ? sw_cfg_reg[`DHC_F_CLEN] : s_clen;
  wire a_async = use_sw ? sw_cfg_reg[`DHC_F_ASYNC] : s_fmt;
  wire [2:0] a_tr = use_sw ? sw_cfg_reg[9:7] : hw_tr;
  wire a_loopctl = use_sw ? sw_cfg_reg[`DHC_F_LOOPCTL] : s_loopctl;
  wire a_guard = use_sw ? sw_cfg_reg[`DHC_F_GUARD] : ~s_guard; // On disables
  wire a_ext = use_sw ? sw_cfg_reg[`DHC_F_EXTDLY] : s_dly;
  wire fast_line = (a_lr == `DHC_LR_56K) || (a_lr == `DHC_LR_64K);

  // ==========================================================
  // Timebase: one pulse per microsecond
  // Zero-based count, so US_CYCLES of 1 ticks on every edge;
  // US_CYCLES above 256 would not fit the 8-bit prescaler
  reg [7:0] us_cnt_reg;
  wire [31:0] us_last = US_CYCLES - 1;
  wire us_tick = (us_cnt_reg == us_last[7:0]);
  always @(posedge mclk) begin
    if (!rstn)
      us_cnt_reg <= 8'h00;
    else
      us_cnt_reg <= us_tick ? 8'h00 : us_cnt_reg + 8'h01;
  end

  // Guard and delay limits in microseconds per line rate
  // Worked out at 32 bits and cut to the counter widths on purpose:
  // with a full second the longest guard needs 25 bits and the longest
  // delay 15 bits. Rates without an entry of their own (64k) use the
  // 56k figures.
  reg [31:0] guard_lim32;
  reg [31:0] dly_lim32;
  wire [25:0] guard_lim = guard_lim32[25:0];
  wire [14:0] dly_lim = dly_lim32[14:0];
  always @* begin
    case (a_lr)
      `DHC_LR_2400: begin
        guard_lim32 = `DHC_GUARD_S_24 * S_US;
        dly_lim32 = a_ext ? `DHC_DLY_E_24 : `DHC_DLY_N_24;
      end
      `DHC_LR_4800: begin
        guard_lim32 = `DHC_GUARD_S_48 * S_US;
        dly_lim32 = a_ext ? `DHC_DLY_E_48 : `DHC_DLY_N_48;
      end
      `DHC_LR_9600: begin
        guard_lim32 = `DHC_GUARD_S_96 * S_US;
        dly_lim32 = a_ext ? `DHC_DLY_E_96 : `DHC_DLY_N_96;
      end
      `DHC_LR_19200: begin
        guard_lim32 = `DHC_GUARD_S_192 * S_US;
        dly_lim32 = a_ext ? `DHC_DLY_E_192 : `DHC_DLY_N_192;
      end
      default: begin
        guard_lim32 = `DHC_GUARD_S_56 * S_US;
        dly_lim32 = a_ext ? `DHC_DLY_E_56 : `DHC_DLY_N_56;
      end
    endcase
  end

  // ==========================================================
  // Anti-stream guard
  // Counts whole microseconds while the terminal holds its request;
  // once forced off it stops counting and waits for the request to drop
  reg [25:0] guard_cnt_reg;
  reg guard_off_reg;
  always @(posedge mclk) begin
    if (!rstn) begin
      guard_cnt_reg <= 26'h0;
      guard_off_reg <= 1'b0;
    end else if (!s_rts) begin
      guard_cnt_reg <= 26'h0; // Release only when terminal drops request
      guard_off_reg <= 1'b0;
    end else if (a_guard && !guard_off_reg && us_tick) begin
      if (guard_cnt_reg >= guard_lim - 26'h1)
        guard_off_reg <= 1'b1; // Forced off after interval
      else
        guard_cnt_reg <= guard_cnt_reg + 26'h1;
    end
  end

  // Effective send request; 64k always forced
  // The guard only cuts a request that the terminal drives; a forced
  // request is never timed out
  wire forced = a_frts || (a_lr == `DHC_LR_64K);
  wire rts_eff = forced || (s_rts && !guard_off_reg);
  // Circuit up check, bypassed without assurance
  wire circuit_ok = !a_ca || (!s_nosig && s_cd);

  // ==========================================================
  // Turn-on delay counter
  // Restarts from zero whenever the effective request drops, so every
  // turn-on waits the full delay for the rate in force at that time
  reg [14:0] dly_cnt_reg;
  reg dly_done_reg;
  always @(posedge mclk) begin
    if (!rstn) begin
      dly_cnt_reg <= 15'h0;
      dly_done_reg <= 1'b0;
    end else if (!rts_eff) begin
      dly_cnt_reg <= 15'h0;
      dly_done_reg <= 1'b0;
    end else if (!dly_done_reg && us_tick) begin
      if (dly_cnt_reg >= dly_lim - 15'h1)
        dly_done_reg <= 1'b1; // Clear after delay
      else
        dly_cnt_reg <= dly_cnt_reg + 15'h1;
    end
  end

  // ==========================================================
  // Registered outputs
  // Every output is a flop, so the pins see no glitch from the decode;
  // the cost is one cycle on top of the synchroniser
  always @(posedge mclk) begin
    if (!rstn) begin
      clear_to_send <= 1'b0;
      tx_enable <= 1'b0;
      local_loop_active <= 1'b0;
      remote_loop_active <= 1'b0;
      line_rate <= `DHC_LR_56K;
      terminal_rate <= `DHC_TR_LINE;
      async_convert <= 1'b0;
      char_len_11 <= 1'b0;
      line_sync <= 1'b1;
    end else begin
      clear_to_send <= rts_eff && dly_done_reg && circuit_ok;
      tx_enable <= rts_eff && circuit_ok;
      local_loop_active <= a_loopctl && s_ll;
      remote_loop_active <= a_loopctl && s_rl;
      line_rate <= a_lr;
      // Slower terminal only on fast lines
      // Unused software codes fall back to no conversion
      terminal_rate <= (fast_line && a_tr <= `DHC_TR_38400) ? a_tr : `DHC_TR_LINE;
      async_convert <= a_async;
      char_len_11 <= a_async && a_clen;
      line_sync <= 1'b1; // Line framing never async
    end
  end

  // ==========================================================
  // Register reads, data valid the cycle after the strobe
  // Zero outside the read cycle, so a stale word is never mistaken for
  // an answer
  always @(posedge mclk) begin
    if (!rstn)
      reg_rdata <= 32'h0;
    else if (reg_rd) begin
      case (reg_addr)
        `DHC_ADDR_CFG: reg_rdata <= {19'h0, sw_cfg_reg};
        `DHC_ADDR_CTL: reg_rdata <= {31'h0, sw_ctl_reg};
        `DHC_ADDR_STAT: reg_rdata <= {24'h0, use_sw, guard_off_reg, clear_to_send, tx_enable,
                                      local_loop_active, line_rate};
        default: reg_rdata <= 32'h0;
      endcase
    end else
      reg_rdata <= 32'h0;
  end

endmodule

// ===== tb/dhc_ctrl_props.sv
/* Checker for the terminal handshake block.
   Assumes it is bound to dhc_ctrl and sees only its ports. */
`timescale 1ns/1ps
module dhc_ctrl_props (
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Register read side
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // Terminal pins and results
  input logic local_loop_request,
  input logic remote_loop_request,
  input logic local_loop_active,
  input logic remote_loop_active,
  input logic clear_to_send,
  input logic tx_enable,
  input logic [2:0] line_rate,
  input logic [2:0] terminal_rate,
  input logic line_sync
);
  // ==========
  // One domain, so one clock and one disable for all
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_line_sync: assert property (line_sync)
    else $error("line not synchronous");
  chk_rate_range: assert property (line_rate <= 3'h5)
    else $error("line rate code out of range");
  chk_term_code: assert property (terminal_rate <= 3'h4 || terminal_rate == 3'h7)
    else $error("terminal rate code illegal");
  chk_slow_term: assert property (terminal_rate != 3'h7 |-> line_rate >= 3'h4)
    else $error("slow terminal on slow line");
  // Pin to output is three registers, so a loop may start only from a request that old
  chk_local_loop: assert property ($rose(local_loop_active) |-> $past(local_loop_request, 3))
    else $error("local loop without request");
  chk_remote_loop: assert property ($rose(remote_loop_active) |-> $past(remote_loop_request, 3))
    else $error("remote loop without request");
  chk_cts_tx: assert property (clear_to_send |-> tx_enable)
    else $error("clear to send without transmitter");
  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind dhc_ctrl dhc_ctrl_props chk_u (.mclk(mclk), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .local_loop_request(local_loop_request), .remote_loop_request(remote_loop_request),
  .local_loop_active(local_loop_active), .remote_loop_active(remote_loop_active),
  .clear_to_send(clear_to_send), .tx_enable(tx_enable), .line_rate(line_rate),
  .terminal_rate(terminal_rate), .line_sync(line_sync));

// ===== tb/dhc_dte_model.sv
/* Terminal equipment model: raises its send request on command and
   counts cycles until clear to send answers. Assumes one mclk domain. */
`timescale 1ns/1ps
module dhc_dte_model (
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Command and handshake
  input logic want_send,
  input logic clear_to_send,
  output logic send_request,
  output logic [31:0] cts_wait
);
  // Counter clears when the request drops, so each turn-on is timed alone
  always @(posedge mclk) begin
    if (!rstn) begin
      send_request <= 1'b0;
      cts_wait <= 32'h0;
    end else begin
      send_request <= want_send;
      if (!send_request)
        cts_wait <= 32'h0;
      else if (!clear_to_send)
        cts_wait <= cts_wait + 32'h1;
    end
  end
endmodule

// ===== tb/tb_top.sv
/* Bench for the handshake block: register tasks, switch and pin stimulus.
   Assumes US_CYCLES of 1 and S_US of 10, so a microsecond is one cycle
   and a guard second is ten. */
`timescale 1ns/1ps
`include "dhc_defs.vh"
module tb_top;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, cts_wait, rd_val;
  logic [2:0] line_rate_switch = 3'h3, sel = 3'h0, line_rate, terminal_rate;
  logic chr_sw = 1'b0, fmt_sw = 1'b0, frts_sw = 1'b0, loop_sw = 1'b0, want_send = 1'b0, grd_sw = 1'b1;
  logic ll_req = 1'b0, rl_req = 1'b0, no_sig = 1'b0, carrier = 1'b1;
  logic send_request, cts, tx, ll_act, rl_act, async_cv, clen11, line_sync;
  int errors = 0, check_count = 0, i, n;
  // Turn-on cases: line code, flags, expected delay
  logic [2:0] dly_lr [5] = '{3'h4, 3'h4, 3'h3, 3'h1, 3'h2};
  logic [6:0] dly_fl [5] = '{7'h00, 7'h40, 7'h00, 7'h00, 7'h40};
  int dly_us [5] = '{300, 1300, 900, 3800, 7500};
  localparam logic [17:0] SEL_TAB = {3'b000, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};

  always #2.5 mclk = ~mclk;

  dhc_ctrl #(.US_CYCLES(1), .S_US(10)) dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_rate_switch(line_rate_switch),
    .assurance_switch(1'b0), .force_rts_switch(frts_sw), .char_len_switch(chr_sw),
    .data_format_switch(fmt_sw), .rate_select_bit0(sel[0]), .rate_select_bit1(sel[1]),
    .rate_select_bit2(sel[2]), .terminal_loop_ctl_switch(loop_sw), .stream_guard_switch(grd_sw),
    .turn_on_delay_switch(1'b0), .send_request(send_request), .local_loop_request(ll_req),
    .remote_loop_request(rl_req), .clear_to_send(cts), .rx_no_signal(no_sig), .carrier_detect(carrier),
    .tx_enable(tx), .local_loop_active(ll_act), .remote_loop_active(rl_act), .line_rate(line_rate),
    .terminal_rate(terminal_rate), .async_convert(async_cv), .char_len_11(clen11), .line_sync(line_sync));

  dhc_dte_model dte_u (.mclk(mclk), .rstn(rstn), .want_send(want_send), .clear_to_send(cts),
    .send_request(send_request), .cts_wait(cts_wait));

  // ==========
  // Bus tasks: one-cycle strobes, read data taken in the following cycle
  // They stand in for the management port and its menu
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // Three cycles of synchroniser latency, with margin
  task settle();
    repeat (6) @(posedge mclk);
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Flags f are {ext delay, guard, loop ctl, async, 11-bit, forced, assurance}
  function logic [31:0] cfg(input logic [2:0] lr, input logic [2:0] tr, input logic [6:0] f);
    cfg = {19'h0, f[6:4], tr, f[3:0], lr};
  endfunction

  // Watchdog: 40000 cycles, about two and a half times the whole sequence
  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  // ==========
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    settle();
    chk("line_rate", 32'(line_rate), 32'h4);
    chk("term_rate", 32'(terminal_rate), 32'h7);
    chk("tx_forced", 32'(tx), 32'h1);
    rd(`DHC_ADDR_CFG, rd_val);
    chk("cfg_reset", rd_val, cfg(3'h4, 3'h7, 7'h02));
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, rd_val);
    chk("unmapped", rd_val, 32'h0);
    // Hardware rate converter on the 56k line
    for (i = 0; i < 6; i++) begin
      sel <= SEL_TAB[i*3 +: 3];
      settle();
      chk("conv_rate", 32'(terminal_rate), (i < 5) ? i : 7);
    end
    line_rate_switch <= 3'h5;
    sel <= 3'h7;
    settle();
    chk("hw_line", 32'(line_rate), 32'h2);
    chk("no_conv", 32'(terminal_rate), 32'h7);
    line_rate_switch <= 3'h3;
    // Loop requests ignored until loop control is on
    {ll_req, rl_req, fmt_sw, chr_sw, frts_sw} <= 5'h1f;
    settle();
    chk("ll_off", 32'(ll_act), 32'h0);
    chk("rl_off", 32'(rl_act), 32'h0);
    chk("async", 32'(async_cv), 32'h1);
    chk("clen11", 32'(clen11), 32'h1);
    chk("tx_follow", 32'(tx), 32'h0);
    loop_sw <= 1'b1;
    settle();
    chk("ll_on", 32'(ll_act), 32'h1);
    chk("rl_on", 32'(rl_act), 32'h1);
    {ll_req, rl_req, fmt_sw} <= 3'h0;
    settle();
    chk("ll_end", 32'(ll_act), 32'h0);
    chk("sync_fmt", 32'(async_cv), 32'h0);
    chk("line_sync", 32'(line_sync), 32'h1);
    // Software control: every line rate, converter only on fast lines
    wr(`DHC_ADDR_CTL, 32'h1);
    for (i = 0; i < 6; i++) begin
      wr(`DHC_ADDR_CFG, cfg(i[2:0], 3'h3, 7'h02));
      settle();
      chk("sw_line", 32'(line_rate), i);
      chk("sw_term", 32'(terminal_rate), (i >= 4) ? 3 : 7);
    end
    rd(`DHC_ADDR_CFG, rd_val);
    chk("cfg_back", rd_val, cfg(3'h5, 3'h3, 7'h02));
    wr(`DHC_ADDR_CFG, cfg(3'h5, 3'h7, 7'h00));
    settle();
    chk("tx_64k", 32'(tx), 32'h1);
    wr(`DHC_ADDR_CFG, cfg(3'h4, 3'h7, 7'h00));
    settle();
    chk("tx_idle", 32'(tx), 32'h0);
    // Circuit assurance against receiver state
    wr(`DHC_ADDR_CFG, cfg(3'h4, 3'h7, 7'h03));
    no_sig <= 1'b1;
    settle();
    chk("ca_nosig", 32'(tx), 32'h0);
    chk("ca_cts", 32'(cts), 32'h0);
    {no_sig, carrier} <= 2'b00;
    settle();
    chk("ca_nocd", 32'(tx), 32'h0);
    carrier <= 1'b1;
    settle();
    chk("ca_ok", 32'(tx), 32'h1);
    repeat (310) @(posedge mclk);
    chk("ca_cts_on", 32'(cts), 32'h1);
    no_sig <= 1'b1;
    settle();
    chk("ca_cts_off", 32'(cts), 32'h0);
    wr(`DHC_ADDR_CFG, cfg(3'h4, 3'h7, 7'h02));
    {no_sig, carrier} <= 2'b10;
    settle();
    chk("no_ca", 32'(tx), 32'h1);
    chk("no_ca_cts", 32'(cts), 32'h1);
    {no_sig, carrier} <= 2'b01;
    // Turn-on delay per rate, normal and extended; latency allowance of 12
    for (i = 0; i < 5; i++) begin
      wr(`DHC_ADDR_CFG, cfg(dly_lr[i], 3'h7, dly_fl[i]));
      settle();
      want_send <= 1'b1;
      for (n = 0; n < 40000 && cts !== 1'b1; n++) @(posedge mclk);
      chk("cts_delay", 32'(cts_wait >= dly_us[i] && cts_wait <= dly_us[i] + 12), 32'h1);
      want_send <= 1'b0;
      settle();
    end
    // Back to the switches, which rule again
    wr(`DHC_ADDR_CTL, 32'h0);
    settle();
    chk("hw_again", 32'(line_rate), 32'h4);
    // Anti-stream guard from the switches: 20 cycles at 56k, 300 at 2.4k
    grd_sw <= 1'b0;
    settle();
    want_send <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("grd_early", 32'(tx), 32'h1);
    repeat (30) @(posedge mclk);
    chk("grd_off", 32'(tx), 32'h0);
    rd(`DHC_ADDR_STAT, rd_val);
    chk("grd_stat", 32'(rd_val[6]), 32'h1);
    want_send <= 1'b0;
    settle();
    want_send <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("grd_rearm", 32'(tx), 32'h1);
    want_send <= 1'b0;
    line_rate_switch <= 3'h7;
    settle();
    want_send <= 1'b1;
    repeat (200) @(posedge mclk);
    chk("grd_24_on", 32'(tx), 32'h1);
    repeat (200) @(posedge mclk);
    chk("grd_24_off", 32'(tx), 32'h0);
    want_send <= 1'b0;
    wrap_up();
  end
endmodule
